// file: core/lpc_power_mode_ctrl.sv
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`include "lpc_cfg.svh"
module lpc_power_mode_ctrl #(
  parameter int NUM_DRV = 9,
  parameter int STARTUP_CYC = `LPC_STARTUP_CYC,
  parameter int IDLE_CYC = `LPC_IDLE_CYC,
  parameter int FAST_CYC = `LPC_FAST_CYC,
  parameter int PWM_STEP_CYC = `LPC_PWM_STEP_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Pins and analog status
  input wire logic i_enable_pin,
  input wire logic i_thermal_shutdown,
  input wire logic [5:0] i_drv_saturated,
  input wire logic i_batt_sufficient,
  // Engines
  input wire lpc_pkg::lpc_engine_t i_engine,
  input wire logic i_engine_pwm_ahead,
  // Outputs
  output lpc_pkg::lpc_power_t o_power,
  output logic [NUM_DRV-1:0] o_drv_on,
  output logic [8*NUM_DRV-1:0] o_drv_current,
  output lpc_pkg::lpc_mode_t o_mode
);
  import lpc_pkg::*;

  if (NUM_DRV != 9 || STARTUP_CYC < 1 || IDLE_CYC < 1 || PWM_STEP_CYC < 1
      || PWM_STEP_CYC > 65536 || FAST_CYC < 1) begin : g_bad_params
    $error("lpc_power_mode_ctrl: unsupported parameters");
  end

  // ==========================================
  // Input synchronisers
  logic [2:0] en_s_q, tsd_s_q, batt_s_q;
  logic [5:0] sat_s1_q, sat_s2_q, sat_s3_q;
  logic en_pin, thermal_shutdown, batt_ok;
  logic [5:0] sat;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_s_q <= 3'h0;
      tsd_s_q <= 3'h0;
      batt_s_q <= 3'h0;
      sat_s1_q <= 6'h00;
      sat_s2_q <= 6'h00;
      sat_s3_q <= 6'h00;
    end else begin
      en_s_q <= {en_s_q[1:0], i_enable_pin};
      tsd_s_q <= {tsd_s_q[1:0], i_thermal_shutdown};
      batt_s_q <= {batt_s_q[1:0], i_batt_sufficient};
      sat_s1_q <= i_drv_saturated;
      sat_s2_q <= sat_s1_q;
      sat_s3_q <= sat_s2_q;
    end
  end

  logic en_pin_q, tsd_q, batt_q;
  logic [5:0] sat_q;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_pin_q <= 1'b0;
      tsd_q <= 1'b0;
      batt_q <= 1'b0;
      sat_q <= 6'h00;
    end else begin
      if (en_s_q[1] == en_s_q[2]) en_pin_q <= en_s_q[2];
      if (tsd_s_q[1] == tsd_s_q[2]) tsd_q <= tsd_s_q[2];
      if (batt_s_q[1] == batt_s_q[2]) batt_q <= batt_s_q[2];
      for (int k = 0; k < 6; k++) begin
        if (sat_s2_q[k] == sat_s3_q[k]) sat_q[k] <= sat_s3_q[k];
      end
    end
  end
  assign en_pin = en_pin_q;
  assign thermal_shutdown = tsd_q;
  assign batt_ok = batt_q;
  assign sat = sat_q;

  // ==========================================
  // Registers
  logic chip_en_q, psave_en_q, offsleep_q, ext_clk_q, log_map_q, tcomp_q;
  logic [1:0] gain_sel_q;
  logic [7:0] dir_pwm_q [NUM_DRV];
  logic [7:0] current_q [NUM_DRV];
  logic [7:0] fader_q [3];
  logic [1:0] fader_map_q [NUM_DRV];
  logic [7:0] filt_q, hyst_q;
  logic wr, soft_rst;
  lpc_mode_t mode_q;
  logic [1:0] gain_q;

  // Word slot decode shared by writes and reads
  function automatic logic slot_hit(input logic [7:0] a, input logic [7:0] base, input int n);
    slot_hit = a == base + 8'(4 * n);
  endfunction : slot_hit

  // Write lands at the edge where the master samples ack high
  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
  assign soft_rst = wr && i_wb_sel[0] && i_wb_adr == `LPC_RESET_OFS
    && i_wb_dat[7:0] == `LPC_RESET_KEY;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
    end
  end

  // Registered writes; soft reset restores defaults
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chip_en_q <= 1'b0;
      psave_en_q <= 1'b0;
      offsleep_q <= 1'b0;
      ext_clk_q <= 1'b0;
      log_map_q <= 1'b0;
      tcomp_q <= 1'b0;
      gain_sel_q <= 2'h0;
      filt_q <= `LPC_GAIN_FILT_DEF;
      hyst_q <= `LPC_GAIN_HYST_DEF;
      for (int k = 0; k < 3; k++) fader_q[k] <= `LPC_FADER_RST;
      for (int k = 0; k < NUM_DRV; k++) begin
        dir_pwm_q[k] <= 8'h00;
        current_q[k] <= `LPC_CURRENT_RST;
        fader_map_q[k] <= 2'h0;
      end
    end else if (soft_rst) begin
      chip_en_q <= 1'b0;
      psave_en_q <= 1'b0;
      offsleep_q <= 1'b0;
      ext_clk_q <= 1'b0;
      log_map_q <= 1'b0;
      tcomp_q <= 1'b0;
      gain_sel_q <= 2'h0;
      filt_q <= `LPC_GAIN_FILT_DEF;
      hyst_q <= `LPC_GAIN_HYST_DEF;
      for (int k = 0; k < 3; k++) fader_q[k] <= `LPC_FADER_RST;
      for (int k = 0; k < NUM_DRV; k++) begin
        dir_pwm_q[k] <= 8'h00;
        current_q[k] <= `LPC_CURRENT_RST;
        fader_map_q[k] <= 2'h0;
      end
    end else if (wr && i_wb_sel[0]) begin
      if (i_wb_adr == `LPC_ENABLE_OFS) chip_en_q <= i_wb_dat[`LPC_EN_BIT];
      if (i_wb_adr == `LPC_MISC_OFS) begin
        psave_en_q <= i_wb_dat[`LPC_MISC_PSAVE_BIT];
        gain_sel_q <= i_wb_dat[`LPC_MISC_GAIN_LSB +: 2];
        offsleep_q <= i_wb_dat[`LPC_MISC_OFFSLEEP_BIT];
        ext_clk_q <= i_wb_dat[`LPC_MISC_EXTCLK_BIT];
      end
      if (i_wb_adr == `LPC_GAINCFG_OFS) begin
        filt_q <= i_wb_dat[7:0];
        hyst_q <= i_wb_dat[15:8];
      end
      for (int k = 0; k < NUM_DRV; k++) begin
        if (slot_hit(i_wb_adr, `LPC_DIRPWM_OFS, k)) dir_pwm_q[k] <= i_wb_dat[7:0];
        if (slot_hit(i_wb_adr, `LPC_CURRENT_OFS, k)) current_q[k] <= i_wb_dat[7:0];
        if (i_wb_adr == `LPC_MAP_OFS) fader_map_q[k] <= i_wb_dat[2*k +: 2];
      end
      if (i_wb_adr == `LPC_MAP_OFS) begin
        log_map_q <= i_wb_dat[`LPC_MAP_LOG_BIT];
        tcomp_q <= i_wb_dat[`LPC_MAP_TCOMP_BIT];
      end
      for (int k = 0; k < 3; k++) begin
        if (slot_hit(i_wb_adr, `LPC_FADER_OFS, k)) fader_q[k] <= i_wb_dat[7:0];
      end
    end
  end

  // Read mux
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0;
    unique case (i_wb_adr)
      `LPC_ENABLE_OFS: rd_d = 32'(chip_en_q) << `LPC_EN_BIT;
      `LPC_MISC_OFS: rd_d = {26'h0, psave_en_q, gain_sel_q, offsleep_q, 1'b0, ext_clk_q};
      `LPC_STATUS_OFS: rd_d = {25'h0, gain_q, thermal_shutdown, 1'b0, 3'(mode_q)};
      `LPC_GAINCFG_OFS: rd_d = {16'h0, hyst_q, filt_q};
      default: begin
        for (int k = 0; k < NUM_DRV; k++) begin
          if (slot_hit(i_wb_adr, `LPC_DIRPWM_OFS, k)) rd_d = {24'h0, dir_pwm_q[k]};
          if (slot_hit(i_wb_adr, `LPC_CURRENT_OFS, k)) rd_d = {24'h0, current_q[k]};
        end
        for (int k = 0; k < 3; k++) begin
          if (slot_hit(i_wb_adr, `LPC_FADER_OFS, k)) rd_d = {24'h0, fader_q[k]};
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) o_wb_dat <= 32'h0;
    else o_wb_dat <= rd_d;
  end

  // ==========================================
  // PWM generation
  logic [11:0] pwm_cnt_q;
  logic [15:0] step_q;
  logic [11:0] duty [NUM_DRV];
  logic [NUM_DRV-1:0] drv_on_d;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_q <= 16'h0;
      pwm_cnt_q <= 12'h0;
    end else if (step_q >= 16'(PWM_STEP_CYC - 1)) begin
      step_q <= 16'h0;
      pwm_cnt_q <= pwm_cnt_q + 12'h1;
    end else begin
      step_q <= step_q + 16'h1;
    end
  end

  function automatic logic [11:0] map_duty(input logic [7:0] v, input logic lg);
    logic [11:0] lin;
    logic [3:0] e;
    lin = {v, v[7:4]};
    e = 4'(v[7:5]);
    if (!lg) map_duty = lin;
    else map_duty = (v == 8'h00) ? 12'h0 : 12'(((13'h20 | {8'h0, v[4:0]}) << e) >> 1);
  endfunction : map_duty

  generate
    for (genvar g = 0; g < NUM_DRV; g++) begin : g_drv
      logic [7:0] src, scaled;
      logic [15:0] prod;
      logic [11:0] d;
      assign src = i_engine.ctrl[g] ? i_engine.pwm[8*g +: 8] : dir_pwm_q[g];
      assign prod = (fader_map_q[g] == 2'h0) ? {src, 8'hFF}
        : src * fader_q[fader_map_q[g] - 2'h1];
      assign scaled = prod[15:8];
      assign d = map_duty(scaled, log_map_q);
      assign duty[g] = tcomp_q ? {1'b0, d[11:1]} : d;
      assign drv_on_d[g] = pwm_cnt_q < duty[g];
      assign o_drv_current[8*g +: 8] = current_q[g];
    end
  endgenerate

  // ==========================================
  // Inactivity timing
  logic [31:0] idle_q;
  logic any_active, idle_long;
  assign any_active = |drv_on_d || i_engine_pwm_ahead;
  assign idle_long = idle_q >= 32'(IDLE_CYC);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) idle_q <= 32'h0;
    else if (any_active || mode_q == LPC_ST_STANDBY) idle_q <= 32'h0;
    else if (!idle_long) idle_q <= idle_q + 32'h1;
  end

  // ==========================================
  // Mode sequencer
  logic [31:0] st_cnt_q;
  logic enabled;
  assign enabled = chip_en_q && en_pin;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= LPC_ST_STANDBY;
      st_cnt_q <= 32'h0;
    end else if (!enabled) begin
      mode_q <= LPC_ST_STANDBY;
      st_cnt_q <= 32'h0;
    end else begin
      unique case (mode_q)
        LPC_ST_STANDBY: begin
          mode_q <= LPC_ST_STARTUP;
          st_cnt_q <= 32'h0;
        end
        LPC_ST_STARTUP: begin
          if (thermal_shutdown) st_cnt_q <= 32'h0;
          else if (st_cnt_q >= 32'(STARTUP_CYC - 1)) mode_q <= LPC_ST_NORMAL;
          else st_cnt_q <= st_cnt_q + 32'h1;
        end
        LPC_ST_NORMAL: begin
          if (thermal_shutdown) begin
            mode_q <= LPC_ST_STARTUP;
            st_cnt_q <= 32'h0;
          end else if (psave_en_q && idle_long) begin
            mode_q <= LPC_ST_PSAVE;
          end
        end
        LPC_ST_PSAVE: begin
          if (any_active) begin
            mode_q <= LPC_ST_WAKE;
            st_cnt_q <= 32'h0;
          end
        end
        LPC_ST_WAKE: begin
          if (st_cnt_q >= 32'(FAST_CYC - 1)) mode_q <= LPC_ST_NORMAL;
          else st_cnt_q <= st_cnt_q + 32'h1;
        end
      endcase
    end
  end

  // ==========================================
  // Charge pump gain control
  logic [7:0] filt_cnt_q, hyst_cnt_q;
  logic want_up, want_down;
  assign want_up = |sat;
  assign want_down = batt_ok && !want_up;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gain_q <= 2'(LPC_PUMP_BYPASS);
      filt_cnt_q <= 8'h0;
      hyst_cnt_q <= 8'h0;
    end else if (lpc_gain_sel_t'(gain_sel_q) != LPC_PUMP_AUTO) begin
      gain_q <= gain_sel_q;
      filt_cnt_q <= 8'h0;
      hyst_cnt_q <= 8'h0;
    end else if (idle_long || mode_q == LPC_ST_PSAVE) begin
      gain_q <= 2'(LPC_PUMP_BYPASS);
      filt_cnt_q <= 8'h0;
    end else if (gain_q != 2'(LPC_PUMP_X15)) begin
      hyst_cnt_q <= 8'h0;
      if (!want_up) filt_cnt_q <= 8'h0;
      else if (filt_cnt_q >= filt_q) begin
        gain_q <= 2'(LPC_PUMP_X15);
        filt_cnt_q <= 8'h0;
      end else filt_cnt_q <= filt_cnt_q + 8'h1;
    end else begin
      filt_cnt_q <= 8'h0;
      if (!want_down) hyst_cnt_q <= 8'h0;
      else if (hyst_cnt_q >= hyst_q) begin
        gain_q <= 2'(LPC_PUMP_BYPASS);
        hyst_cnt_q <= 8'h0;
      end else hyst_cnt_q <= hyst_cnt_q + 8'h1;
    end
  end

  // ==========================================
  // Power outputs
  logic active, run, off_sleep;
  lpc_power_t pwr_d;
  assign active = mode_q == LPC_ST_NORMAL || mode_q == LPC_ST_WAKE;
  assign run = active || mode_q == LPC_ST_PSAVE;
  assign off_sleep = offsleep_q && active && !(|drv_on_d);

  always_comb begin
    pwr_d.pump_enable = active && gain_q != 2'(LPC_PUMP_OFF) && !off_sleep;
    pwr_d.pump_x15 = pwr_d.pump_enable && gain_q == 2'(LPC_PUMP_X15);
    pwr_d.pump_weak = mode_q == LPC_ST_PSAVE;
    pwr_d.out_pulldown = !run || gain_q == 2'(LPC_PUMP_OFF);
    pwr_d.analog_on = active && !off_sleep || mode_q == LPC_ST_PSAVE && !ext_clk_q;
    pwr_d.drivers_on = active;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_power <= '0;
      o_drv_on <= '0;
      o_mode <= LPC_ST_STANDBY;
    end else begin
      o_power <= pwr_d;
      o_drv_on <= active ? drv_on_d : '0;
      o_mode <= mode_q;
    end
  end

  // ==========================================
  // Assertions
  a_standby_when_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !enabled |=> mode_q == LPC_ST_STANDBY) else $error("not standby when disabled");
  a_tsd_holds_start: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    mode_q == LPC_ST_STARTUP && thermal_shutdown && enabled |=> mode_q == LPC_ST_STARTUP)
    else $error("left startup under thermal shutdown");
  a_startup_exit: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(mode_q == LPC_ST_NORMAL) |-> $past(mode_q) != LPC_ST_STARTUP || !$past(thermal_shutdown))
    else $error("startup exit with thermal shutdown");
  a_pump_off_pull: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    gain_q == 2'(LPC_PUMP_OFF) |=> o_power.out_pulldown && !o_power.pump_enable)
    else $error("pump off without pull-down");
  a_forced_gain: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    gain_sel_q != 2'(LPC_PUMP_AUTO) && !soft_rst |=> gain_q == $past(gain_sel_q))
    else $error("forced gain not applied");
  a_psave_weak: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    mode_q == LPC_ST_PSAVE |=> o_power.pump_weak && o_drv_on == '0)
    else $error("power save outputs wrong");
  a_psave_entry: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(mode_q == LPC_ST_PSAVE) |-> $past(psave_en_q) && $past(idle_long))
    else $error("power save entered early");
  a_wake_exit: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    mode_q == LPC_ST_PSAVE && any_active && enabled |=> mode_q == LPC_ST_WAKE)
    else $error("no wake on activity");
  a_soft_reset: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    soft_rst |=> !chip_en_q && dir_pwm_q[0] == 8'h00 && gain_sel_q == 2'h0)
    else $error("soft reset left state");
  a_idle_restart: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    |drv_on_d |=> idle_q == 32'h0) else $error("idle timer not restarted");
endmodule : lpc_power_mode_ctrl

// file: core/lpc_cfg.svh
// What this block does
// - Pump select zero disables pump and enables output pull-down discharge.
// - Bypass connects battery to sources; 1.5x regulates output to 4.5 V.
// - Auto mode picks 1.5x when any of drivers one to six saturate.
// - Auto mode returns to 1x when battery suffices for all active LEDs.
// - Auto mode drops to bypass after all LEDs idle over 50 ms.
// - Gain changes are filtered against transients with configurable hysteresis.
// - Each of nine drivers has an 8-bit current register, 100 uA steps.
// - PWM dimming at 312 Hz, 12-bit internal duty, 8-bit user control.
// - Log or linear brightness mapping applies to engine and direct control.
// - Temperature compensation limits maximum duty to half scale.
// - Nine direct PWM registers; drivers follow them after reset.
// - Engine PWM value overrides direct register when engine controls driver.
// - Three master faders scale the brightness of their assigned drivers.
// - Power-on reset or FFH written to reset register restores all defaults.
// - After power-on reset device goes to standby; enable bit resets low.
// - Standby while enable bit or enable pin low; registers stay writable.
// - Both enables high start a 500 us startup before normal operation.
// - Thermal shutdown in startup or normal mode holds the device in startup until it clears.
// - Auto power save enters when engines predict no PWM for over 50 ms.
// - Power save puts pump in weak 1x; blocks off depend on clock source.
// - PWM demand during power save starts a fast startup to exit.
// - Misc bit 2 powers analog blocks down during each PWM off-time.
`ifndef LPC_CFG_SVH
`define LPC_CFG_SVH

// ==========================================
// Register offsets (byte addresses)
`define LPC_ENABLE_OFS 8'h00
`define LPC_DIRPWM_OFS 8'h80
`define LPC_CURRENT_OFS 8'hB0
`define LPC_FADER_OFS 8'h48
`define LPC_MISC_OFS 8'h36
`define LPC_RESET_OFS 8'h3D
`define LPC_STATUS_OFS 8'h3A
`define LPC_MAP_OFS 8'h70
`define LPC_ENGINE_OFS 8'h74
`define LPC_GAINCFG_OFS 8'h78

// ==========================================
// Field positions and values
`define LPC_EN_BIT 6
`define LPC_MISC_PSAVE_BIT 5
`define LPC_MISC_GAIN_LSB 3
`define LPC_MISC_OFFSLEEP_BIT 2
`define LPC_MISC_EXTCLK_BIT 0
`define LPC_MAP_LOG_BIT 9
`define LPC_MAP_TCOMP_BIT 10
`define LPC_RESET_KEY 8'hFF
`define LPC_CURRENT_RST 8'hAF
`define LPC_FADER_RST 8'hFF

// ==========================================
// Timing
`define LPC_CLK_HZ 100000000
`define LPC_STARTUP_US 500
`define LPC_IDLE_MS 50
`define LPC_PWM_HZ 312
`define LPC_FAST_START_US 20
`define LPC_STARTUP_CYC (`LPC_STARTUP_US * (`LPC_CLK_HZ / 1000000))
`define LPC_FAST_CYC (`LPC_FAST_START_US * (`LPC_CLK_HZ / 1000000))
`define LPC_IDLE_CYC (`LPC_IDLE_MS * (`LPC_CLK_HZ / 1000))
`define LPC_PWM_STEP_CYC (`LPC_CLK_HZ / (`LPC_PWM_HZ * 4096))
`define LPC_GAIN_FILT_DEF 8'h10
`define LPC_GAIN_HYST_DEF 8'h40

`endif

// file: core/lpc_pkg.sv
package lpc_pkg;
  typedef enum logic [1:0] {
    LPC_PUMP_OFF,
    LPC_PUMP_BYPASS,
    LPC_PUMP_X15,
    LPC_PUMP_AUTO
  } lpc_gain_sel_t;

  typedef enum {
    LPC_ST_STANDBY,
    LPC_ST_STARTUP,
    LPC_ST_NORMAL,
    LPC_ST_PSAVE,
    LPC_ST_WAKE
  } lpc_mode_t;

  typedef struct packed {
    logic pump_enable;
    logic pump_x15;
    logic pump_weak;
    logic out_pulldown;
    logic analog_on;
    logic drivers_on;
  } lpc_power_t;

  typedef struct packed {
    logic [8:0] ctrl;
    logic [71:0] pwm;
  } lpc_engine_t;
endpackage : lpc_pkg

// file: test/lpc_analog_model.sv
`timescale 1ns/100ps
// ==========================================
// Analog side: pump, drivers, battery and temperature
module lpc_analog_model (
  // Clock and power state from the block
  input wire logic i_mclk,
  input wire lpc_pkg::lpc_power_t i_power,
  // Bench controls
  input wire logic i_hot,
  input wire logic i_sat_req,
  input wire logic i_batt_req,
  // Status towards the block
  output logic o_thermal_shutdown,
  output logic [5:0] o_drv_saturated,
  output logic o_batt_sufficient
);
  import lpc_pkg::*;
  // Overtemperature held while the die is hot
  always_ff @(posedge i_mclk) begin
    o_thermal_shutdown <= i_hot;
  end
  // Headroom lost on drivers one to six until the pump boosts
  always_ff @(posedge i_mclk) begin
    o_drv_saturated <= {6{i_sat_req & ~i_power.pump_x15}};
  end
  // Battery level good enough for plain 1x
  always_ff @(posedge i_mclk) begin
    o_batt_sufficient <= i_batt_req;
  end
endmodule : lpc_analog_model

// file: test/led_driver_power_mode_ctrl_tb.sv
`timescale 1ns/100ps
`include "lpc_cfg.svh"
module led_driver_power_mode_ctrl_tb;
  import lpc_pkg::*;
  logic i_mclk, i_rst_n, cyc, stb, we, pin, hot, sat_req, batt_req, thermal_shutdown, batt, ahead;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, o_wb_dat, q, rnd;
  logic o_wb_ack;
  logic [5:0] sat;
  lpc_engine_t eng;
  lpc_power_t o_power;
  logic [8:0] o_drv_on;
  logic [71:0] o_drv_current;
  lpc_mode_t o_mode;
  int fail_count, n_tests, k, g, cnt, c1;
  logic [7:0] v;
  // ==========================================
  // Design and analog partner
  lpc_power_mode_ctrl #(.STARTUP_CYC(20), .IDLE_CYC(100), .FAST_CYC(5),
    .PWM_STEP_CYC(1)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_enable_pin(pin),
    .i_thermal_shutdown(thermal_shutdown), .i_drv_saturated(sat), .i_batt_sufficient(batt),
    .i_engine(eng), .i_engine_pwm_ahead(ahead), .o_power(o_power),
    .o_drv_on(o_drv_on), .o_drv_current(o_drv_current), .o_mode(o_mode));
  lpc_analog_model u_model (.i_mclk(i_mclk), .i_power(o_power), .i_hot(hot),
    .i_sat_req(sat_req), .i_batt_req(batt_req), .o_thermal_shutdown(thermal_shutdown),
    .o_drv_saturated(sat), .o_batt_sufficient(batt));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // ==========================================
  // Helpers
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function logic probe(input int s);
    logic [5:0] pw;
    pw = o_power;
    return (s < 6) ? pw[s] : o_drv_on[0];
  endfunction : probe
  task give_verdict();
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : check
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; wdat <= d;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    q = o_wb_dat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) begin
      check(0, 1);
      give_verdict();
    end
  endtask : wb
  task wait_bit(input int s, input logic e, input int n);
    int i;
    for (i = 0; i < n && probe(s) !== e; i++) @(posedge i_mclk);
    check(probe(s), e);
  endtask : wait_bit
  task wait_mode(input lpc_mode_t m, input int n);
    int i;
    for (i = 0; i < n && o_mode !== m; i++) @(posedge i_mclk);
    check(32'(o_mode), 32'(m));
  endtask : wait_mode
  // One full PWM period of high samples on a probed bit
  task count_on(input int s, output int c);
    repeat (4) @(posedge i_mclk);
    c = 0;
    repeat (4096) begin
      @(posedge i_mclk);
      if (probe(s) === 1'b1) c++;
    end
  endtask : count_on
  // ==========================================
  // Scenarios
  initial begin
    i_rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    wdat = 32'h0; pin = 1'b0; hot = 1'b0; sat_req = 1'b0; batt_req = 1'b0;
    ahead = 1'b0; eng = '0; fail_count = 0; n_tests = 0; rnd = 32'h1E397CED;
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    check(32'(o_mode), 32'(LPC_ST_STANDBY));
    check(32'(o_power), 32'h0);
    wb(1'b0, `LPC_CURRENT_OFS, 32'h0);
    check(q, 32'(`LPC_CURRENT_RST));
    check(32'(o_power), 32'h4);
    for (g = 0; g < 3; g++) begin
      rnd = lfsr(rnd);
      k = rnd[9:8];
      v = rnd[7:0];
      wb(1'b1, `LPC_CURRENT_OFS + 8'(4 * k), {24'h0, v});
      wb(1'b0, `LPC_CURRENT_OFS + 8'(4 * k), 32'h0);
      check(q, {24'h0, v});
      check(o_drv_current[8 * k +: 8], v);
    end
    wb(1'b0, 8'hF0, 32'h0);
    check(q, 32'h0);
    hot <= 1'b1;
    pin <= 1'b1;
    wb(1'b1, `LPC_ENABLE_OFS, 32'h40);
    wait_mode(LPC_ST_STARTUP, 50);
    repeat (60) @(posedge i_mclk);
    check(32'(o_mode), 32'(LPC_ST_STARTUP));
    hot <= 1'b0;
    wait_mode(LPC_ST_NORMAL, 100);
    wb(1'b1, `LPC_DIRPWM_OFS, 32'hFF);
    wait_bit(6, 1'b1, 5000);
    for (g = 0; g < 3; g++) begin
      wb(1'b1, `LPC_MISC_OFS, 32'(g << 3));
      wait_bit(2, g == 0, 20);
      wait_bit(4, g == 2, 20);
    end
    check(32'(o_power), 32'h33);
    sat_req <= 1'b1;
    wb(1'b1, `LPC_MISC_OFS, 32'h18);
    wait_bit(4, 1'b1, 300);
    sat_req <= 1'b0;
    batt_req <= 1'b1;
    wait_bit(4, 1'b0, 500);
    batt_req <= 1'b0;
    sat_req <= 1'b1;
    wait_bit(4, 1'b1, 300);
    sat_req <= 1'b0;
    count_on(6, c1);
    check(c1 >= 32'hFF0, 1'b1);
    wb(1'b1, `LPC_MAP_OFS, 32'h400);
    count_on(6, cnt);
    check(cnt, c1 >> 1);
    wb(1'b1, `LPC_DIRPWM_OFS, 32'h80);
    wb(1'b1, `LPC_MAP_OFS, 32'h0);
    count_on(6, c1);
    wb(1'b1, `LPC_MAP_OFS, 32'h200);
    count_on(6, cnt);
    check(cnt < c1, 1'b1);
    wb(1'b1, `LPC_MAP_OFS, 32'h1);
    wb(1'b1, `LPC_FADER_OFS, 32'h0);
    count_on(6, cnt);
    check(cnt, 32'h0);
    wb(1'b1, `LPC_MAP_OFS, 32'h0);
    wb(1'b1, `LPC_MISC_OFS, 32'h1C);
    count_on(1, cnt);
    check(cnt, c1);
    eng.ctrl <= 9'h001;
    eng.pwm <= 72'h0;
    repeat (10) @(posedge i_mclk);
    cnt = 0;
    repeat (4200) begin
      @(posedge i_mclk);
      if (o_drv_on[0] !== 1'b0) cnt++;
    end
    check(cnt, 0);
    check(o_power.pump_x15, 1'b0);
    wb(1'b1, `LPC_MISC_OFS, 32'h39);
    wait_mode(LPC_ST_PSAVE, 2000);
    check(o_power.pump_weak, 1'b1);
    check(o_power.analog_on, 1'b0);
    ahead <= 1'b1;
    wait_mode(LPC_ST_NORMAL, 500);
    pin <= 1'b0;
    wait_mode(LPC_ST_STANDBY, 50);
    wb(1'b1, `LPC_RESET_OFS, 32'hFF);
    wb(1'b0, `LPC_CURRENT_OFS + 8'(4 * k), 32'h0);
    check(q, 32'(`LPC_CURRENT_RST));
    wb(1'b0, `LPC_ENABLE_OFS, 32'h0);
    check(q[6], 1'b0);
    give_verdict();
  end
endmodule : led_driver_power_mode_ctrl_tb
